// ### inc/rcg_consts.vh
`ifndef RCG_CONSTS_VH
`define RCG_CONSTS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCG_CLK_MHZ 25
`define RCG_MIN_PULSE_US 1000
`define RCG_TENTH_MS 100

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RCG_OFF_CTRL 12'h000
`define RCG_OFF_QSTOP 12'h004
`define RCG_OFF_DEC 12'h008
`define RCG_OFF_FSEL_LO 12'h00c
`define RCG_OFF_FSEL_HI 12'h010
`define RCG_OFF_STATUS 12'h014

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define RCG_CTRL_LATCH 0
`define RCG_CTRL_POLICY 1
`define RCG_CTRL_ACT_LO 2
`define RCG_CTRL_ACT_HI 3
`define RCG_CTRL_RST 4'h2
`define RCG_QSTOP_RST 13'h0032
`define RCG_DEC_RST 13'h0064
`define RCG_TIME_MAX 13'h1770
`define RCG_FSEL_RST 32'h0000_0000

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define RCG_FSEL_RUN_EN 6'h0d
`define RCG_STOP_COAST 2'h0
`define RCG_STOP_QSTOP 2'h1
`define RCG_STOP_QRES 2'h2

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define RCG_ST_DRIVE 0
`define RCG_ST_DIR 1
`define RCG_ST_DECEL 2
`define RCG_ST_QUICK 3
`define RCG_ST_PERMIT 4
`define RCG_ST_LFWD 5
`define RCG_ST_LREV 6
`define RCG_ST_STATE_LO 8
`define RCG_ST_STATE_HI 12
`define RCG_ST_REM_LO 16
`define RCG_ST_REM_HI 28

`endif

// ### rtl/rcg_run_gate.v
// Contract
// - in latched mode a qualified forward or reverse press is held after release.
// - a press shorter than 1 ms is not taken as a run command in latched mode.
// - in latched mode forward and reverse together stop operation.
// - a terminal whose function select holds 13 is the run-permit input.
// - with run-enable policy 0 the permit terminal is ignored.
// - with run-enable policy 1 run is accepted only while the permit is active.
// - permit withdrawn under a quick-stop action decelerates on the quick time.
// - run command off with permit active decelerates on the normal time.
// - under coast action a dropped permit blocks the output at once.
// - after a plain quick stop only a new run command restarts the drive.
// - after quick stop with resume a present command and permit restart it.
// - quick-stop time runs 0.0 to 600.0 s in tenths, default 5.0 s.
// - the quick-stop time is used only by the two quick-stop actions.
`timescale 1ns/1ps
`include "rcg_consts.vh"

module rcg_run_gate #(
    parameter [31:0] MIN_PULSE_CYCLES = `RCG_MIN_PULSE_US * `RCG_CLK_MHZ,
    parameter [31:0] TENTH_CYCLES = `RCG_TENTH_MS * 1000 * `RCG_CLK_MHZ
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire fwd_in,
    input wire rev_in,
    input wire stop_closed,
    input wire [7:0] term_in,
    output reg drive_en,
    output reg dir_rev,
    output reg decel_active,
    output reg quick_decel
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam [15:0] MINP = MIN_PULSE_CYCLES[15:0];
    localparam [21:0] TENTHP = TENTH_CYCLES[21:0];
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RUN = 5'h02;
    localparam [4:0] S_DEC = 5'h04;
    localparam [4:0] S_QDEC = 5'h08;
    localparam [4:0] S_HOLD = 5'h10;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    reg [3:0] ctrl_q;
    reg [12:0] qstop_q;
    reg [12:0] dec_q;
    reg [31:0] fsel_lo_q;
    reg [31:0] fsel_hi_q;
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_ctrl = (paddr == `RCG_OFF_CTRL);
    wire hit_qstop = (paddr == `RCG_OFF_QSTOP);
    wire hit_dec = (paddr == `RCG_OFF_DEC);
    wire hit_flo = (paddr == `RCG_OFF_FSEL_LO);
    wire hit_fhi = (paddr == `RCG_OFF_FSEL_HI);
    wire hit_st = (paddr == `RCG_OFF_STATUS);
    wire mapped = hit_ctrl | hit_qstop | hit_dec | hit_flo | hit_fhi | hit_st;
    wire [12:0] wtime;

    // single-cycle access: data is staged in setup, so pready never waits
    assign pready = access;
    assign pslverr = access & ~mapped;
    // out-of-range times clamp rather than error
    assign wtime = (pwdata[31:13] != 19'h0_0000 ||
                    pwdata[12:0] > `RCG_TIME_MAX) ?
                   `RCG_TIME_MAX : pwdata[12:0];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `RCG_CTRL_RST;
            qstop_q <= `RCG_QSTOP_RST;
            dec_q <= `RCG_DEC_RST;
            fsel_lo_q <= `RCG_FSEL_RST;
            fsel_hi_q <= `RCG_FSEL_RST;
        end
        else if (wr)
        begin
            if (hit_ctrl)
                ctrl_q <= pwdata[3:0];
            if (hit_qstop)
                qstop_q <= wtime;
            if (hit_dec)
                dec_q <= wtime;
            if (hit_flo)
                fsel_lo_q <= pwdata;
            if (hit_fhi)
                fsel_hi_q <= pwdata;
        end
    end

    wire latch_mode = ctrl_q[`RCG_CTRL_LATCH];
    wire policy = ctrl_q[`RCG_CTRL_POLICY];
    wire [1:0] action = ctrl_q[`RCG_CTRL_ACT_HI:`RCG_CTRL_ACT_LO];
    wire act_quick = (action == `RCG_STOP_QSTOP) ||
                     (action == `RCG_STOP_QRES);

    // ----------------------------------------------------------------
    // run permit
    // ----------------------------------------------------------------
    wire [63:0] fsel_all = {fsel_hi_q, fsel_lo_q};
    wire [7:0] term_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_term
            assign term_hit[gi] = term_in[gi] &
                (fsel_all[gi*8 +: 6] == `RCG_FSEL_RUN_EN);
        end
    endgenerate
    // policy 0 forces permit; policy 1 needs a configured, active terminal
    wire permit = ~policy | (|term_hit);

    // ----------------------------------------------------------------
    // pulse qualification
    // ----------------------------------------------------------------
    wire [1:0] raw_in = {rev_in, fwd_in};
    wire [1:0] qual;
    wire [1:0] press;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_qual
            reg [15:0] cnt_q;
            reg qual_q;
            reg qprev_q;
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cnt_q <= 16'h0000;
                    qual_q <= 1'b0;
                    qprev_q <= 1'b0;
                end
                else
                begin
                    qprev_q <= qual_q;
                    if (!raw_in[gi])
                    begin
                        cnt_q <= 16'h0000;
                        qual_q <= 1'b0;
                    end
                    else
                    begin
                        if (cnt_q != MINP)
                            cnt_q <= cnt_q + 16'h0001;
                        qual_q <= (cnt_q == MINP);
                    end
                end
            end
            assign qual[gi] = qual_q;
            assign press[gi] = qual_q & ~qprev_q;
        end
    endgenerate

    // ----------------------------------------------------------------
    // command latch
    // ----------------------------------------------------------------
    reg lfwd_q;
    reg lrev_q;
    wire both_raw = fwd_in & rev_in;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lfwd_q <= 1'b0;
            lrev_q <= 1'b0;
        end
        else if (!latch_mode || !stop_closed || both_raw)
        begin
            // open stop or both directions drop any held command
            lfwd_q <= 1'b0;
            lrev_q <= 1'b0;
        end
        else if (press[0])
        begin
            lfwd_q <= 1'b1;
            lrev_q <= 1'b0;
        end
        else if (press[1])
        begin
            lfwd_q <= 1'b0;
            lrev_q <= 1'b1;
        end
    end

    // two-wire mode follows the levels; both high is treated as no run
    wire cmd_fwd = latch_mode ? lfwd_q : (fwd_in & ~rev_in);
    wire cmd_rev = latch_mode ? lrev_q : (rev_in & ~fwd_in);
    wire run_cmd = cmd_fwd | cmd_rev;
    reg run_prev_q;
    wire new_cmd = (run_cmd & ~run_prev_q) |
                   (latch_mode & (|press) & ~both_raw);

    // ----------------------------------------------------------------
    // deceleration timer
    // ----------------------------------------------------------------
    reg [21:0] presc_q;
    reg [12:0] rem_q;
    wire tick = (presc_q == TENTHP - 22'h00_0001);
    wire timer_done = (rem_q == 13'h0000);

    // ----------------------------------------------------------------
    // drive sequencer
    // ----------------------------------------------------------------
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg load_q;
    reg load_quick;
    reg load_norm;

    always @*
    begin
        state_d = state_q;
        load_quick = 1'b0;
        load_norm = 1'b0;
        case (state_q)
            S_IDLE:
            begin
                if (run_cmd && permit)
                    state_d = S_RUN;
            end
            S_RUN:
            begin
                if (!permit)
                begin
                    if (act_quick)
                    begin
                        state_d = S_QDEC;
                        load_quick = 1'b1;
                    end
                    else
                        state_d = S_IDLE;
                end
                else if (!run_cmd || (cmd_rev != dir_rev))
                begin
                    state_d = S_DEC;
                    load_norm = 1'b1;
                end
            end
            S_DEC:
            begin
                if (!permit && !act_quick)
                    state_d = S_IDLE;
                else if (!permit)
                begin
                    state_d = S_QDEC;
                    load_quick = 1'b1;
                end
                else if (run_cmd && (cmd_rev == dir_rev))
                    state_d = S_RUN;
                else if (timer_done)
                    state_d = S_IDLE;
            end
            S_QDEC:
            begin
                if (timer_done)
                begin
                    if (action == `RCG_STOP_QRES)
                        state_d = S_IDLE;
                    else
                        state_d = S_HOLD;
                end
            end
            S_HOLD:
            begin
                // permit returning alone is not enough to restart
                if (new_cmd && run_cmd && permit)
                    state_d = S_RUN;
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            run_prev_q <= 1'b0;
            load_q <= 1'b0;
            presc_q <= 22'h00_0000;
            rem_q <= 13'h0000;
            drive_en <= 1'b0;
            dir_rev <= 1'b0;
            decel_active <= 1'b0;
            quick_decel <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            run_prev_q <= run_cmd;
            load_q <= load_quick | load_norm;
            if (load_quick)
            begin
                rem_q <= qstop_q;
                presc_q <= 22'h00_0000;
            end
            else if (load_norm)
            begin
                rem_q <= dec_q;
                presc_q <= 22'h00_0000;
            end
            else if (tick)
            begin
                presc_q <= 22'h00_0000;
                if (!timer_done)
                    rem_q <= rem_q - 13'h0001;
            end
            else
                presc_q <= presc_q + 22'h00_0001;
            if (state_d == S_RUN && state_q != S_RUN)
                dir_rev <= cmd_rev;
            drive_en <= (state_d == S_RUN) || (state_d == S_DEC) ||
                        (state_d == S_QDEC);
            decel_active <= (state_d == S_DEC) || (state_d == S_QDEC);
            quick_decel <= (state_d == S_QDEC);
        end
    end

    // ----------------------------------------------------------------
    // read data, staged in the setup phase
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;
    always @*
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux[3:0] = ctrl_q;
        else if (hit_qstop)
            rd_mux[12:0] = qstop_q;
        else if (hit_dec)
            rd_mux[12:0] = dec_q;
        else if (hit_flo)
            rd_mux = fsel_lo_q;
        else if (hit_fhi)
            rd_mux = fsel_hi_q;
        else if (hit_st)
        begin
            rd_mux[`RCG_ST_DRIVE] = drive_en;
            rd_mux[`RCG_ST_DIR] = dir_rev;
            rd_mux[`RCG_ST_DECEL] = decel_active;
            rd_mux[`RCG_ST_QUICK] = quick_decel;
            rd_mux[`RCG_ST_PERMIT] = permit;
            rd_mux[`RCG_ST_LFWD] = lfwd_q;
            rd_mux[`RCG_ST_LREV] = lrev_q;
            rd_mux[`RCG_ST_STATE_HI:`RCG_ST_STATE_LO] = state_q;
            rd_mux[`RCG_ST_REM_HI:`RCG_ST_REM_LO] = rem_q;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

endmodule // rcg_run_gate

// ### sim/rcg_buttons.sv
`timescale 1ns/1ps
// ------------------------------------------
// push buttons and switches on the terminals
// ------------------------------------------
module rcg_buttons (
    input wire pclk,
    output logic fwd_in,
    output logic rev_in,
    output logic stop_closed,
    output logic [7:0] term_in
);
    initial
    begin
        fwd_in = 1'b0;
        rev_in = 1'b0;
        stop_closed = 1'b1;
        term_in = 8'h00;
    end
    task hold(input logic f, input logic r);
        @(posedge pclk);
        fwd_in <= f;
        rev_in <= r;
    endtask
    // caller picks n, short ones on purpose only
    task press(input logic f, input logic r, input int n);
        hold(f, r);
        repeat (n) @(posedge pclk);
        fwd_in <= 1'b0;
        rev_in <= 1'b0;
    endtask
    task open_stop;
        @(posedge pclk);
        stop_closed <= 1'b0;
        repeat (3) @(posedge pclk);
        stop_closed <= 1'b1;
    endtask
    task permit(input logic b);
        @(posedge pclk);
        term_in[0] <= b;
    endtask
    // whole terminal byte, so unconfigured terminals get exercised too
    task terms(input logic [7:0] b);
        @(posedge pclk);
        term_in <= b;
    endtask
endmodule // rcg_buttons

// ### sim/rcg_run_gate_properties.sv
`timescale 1ns/1ps
`include "rcg_consts.vh"
// ------------------------------------------
// checker
// ------------------------------------------
module rcg_run_gate_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire fwd_in,
    input wire rev_in,
    input wire stop_closed,
    input wire [7:0] term_in,
    input wire drive_en,
    input wire dir_rev,
    input wire decel_active,
    input wire quick_decel
);
    reg [3:0] ctrl_q;
    reg [63:0] fsel_q;
    reg permit;
    integer i;
    wire wr = psel && penable && pwrite;
    // shadow of the settings, so rules can be judged at the pins
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `RCG_CTRL_RST;
            fsel_q <= {2{`RCG_FSEL_RST}};
        end
        else if (wr)
        begin
            if (paddr == `RCG_OFF_CTRL) ctrl_q <= pwdata[3:0];
            if (paddr == `RCG_OFF_FSEL_LO) fsel_q[31:0] <= pwdata;
            if (paddr == `RCG_OFF_FSEL_HI) fsel_q[63:32] <= pwdata;
        end
    end
    always @*
    begin
        permit = 1'b0;
        for (i = 0; i < 8; i = i + 1)
            if (fsel_q[i*8 +: 6] == `RCG_FSEL_RUN_EN && term_in[i]) permit = 1'b1;
    end
    wire latch = ctrl_q[0];
    wire pol = ctrl_q[1];
    wire coast = ctrl_q[3:2] == 2'h0 || ctrl_q[3:2] == 2'h3;
    wire go = !pol || permit;
    wire run = drive_en && !decel_active;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_reset_blocked: assert property (
        $rose(presetn) |-> !drive_en && !decel_active)
        else $error("output not blocked after reset");
    chk_permit_gate: assert property (
        pol && !permit && !$past(permit) && !drive_en |=> !drive_en)
        else $error("run without permit");
    chk_coast_block: assert property (
        coast && pol && drive_en && $fell(permit) |-> ##[1:2] !drive_en)
        else $error("coast did not block output");
    chk_quick_start: assert property (
        !coast && pol && run && $fell(permit) |-> ##[1:2] quick_decel)
        else $error("quick decel not started");
    chk_quick_decel: assert property (
        quick_decel |-> decel_active)
        else $error("quick decel without decel");
    chk_coast_no_quick: assert property (
        coast && !quick_decel |=> !quick_decel)
        else $error("quick decel under coast");
    chk_stop_open: assert property (
        latch && !stop_closed && !fwd_in && !rev_in && go && run
        |-> ##[1:3] (decel_active && !quick_decel))
        else $error("open stop did not decel");
    chk_both_stop: assert property (
        latch && fwd_in && rev_in && go && run |-> ##[1:3] decel_active)
        else $error("both inputs did not stop");
    cov_quick: cover property ($rose(quick_decel));
    cov_coast: cover property (coast && $fell(drive_en));
    cov_decel: cover property (decel_active && !quick_decel);
endmodule // rcg_run_gate_chk

bind rcg_run_gate rcg_run_gate_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fwd_in(fwd_in), .rev_in(rev_in), .stop_closed(stop_closed),
    .term_in(term_in), .drive_en(drive_en), .dir_rev(dir_rev),
    .decel_active(decel_active), .quick_decel(quick_decel));

// ### sim/rcg_run_gate_test.sv
`timescale 1ns/1ps
`include "rcg_consts.vh"
// ------------------------------------------
// testbench
// ------------------------------------------
module rcg_run_gate_test;
    logic pclk, presetn, psel, penable, pwrite, err, pslverr, pready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic fwd_in, rev_in, stop_closed, drive_en, dir_rev, dec, qdec;
    logic [7:0] term_in;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    rcg_buttons u_btn (.pclk(pclk), .fwd_in(fwd_in), .rev_in(rev_in),
        .stop_closed(stop_closed), .term_in(term_in));
    // short counts keep the timed stops within a few dozen cycles
    rcg_run_gate #(.MIN_PULSE_CYCLES(32'h0000_0008),
        .TENTH_CYCLES(32'h0000_0004)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fwd_in(fwd_in), .rev_in(rev_in), .stop_closed(stop_closed),
        .term_in(term_in), .drive_en(drive_en), .dir_rev(dir_rev),
        .decel_active(dec), .quick_decel(qdec));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task stop_test;
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            stop_test;
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task chk1(input string n, input logic s, input logic e);
        chk(n, {31'h0, s}, {31'h0, e});
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        chk1("pready_setup", pready, 1'b0);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    task rd(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, d, e);
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    initial
    begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl", `RCG_OFF_CTRL, 32'h0000_0002);
        rd("qstop", `RCG_OFF_QSTOP, 32'h0000_0032);
        chk1("drive_rst", drive_en, 1'b0);
        wr(`RCG_OFF_QSTOP, 32'h0000_1771);
        rd("qstop_max", `RCG_OFF_QSTOP, 32'h0000_1770);
        chk1("slverr_ok", err, 1'b0);
        rd("unmapped", 12'h018, 32'h0000_0000);
        chk1("slverr", err, 1'b1);
        wr(`RCG_OFF_QSTOP, 32'h0000_0002);
        wr(`RCG_OFF_DEC, 32'h0000_0002);
        wr(`RCG_OFF_FSEL_LO, 32'h0000_000d);
        wr(`RCG_OFF_CTRL, 32'h0000_0003);
        u_btn.permit(1'b1);
        u_btn.press(1'b1, 1'b0, 4);
        wt(20);
        chk1("short", drive_en, 1'b0);
        u_btn.press(1'b1, 1'b0, 12);
        wt(6);
        chk1("latched", drive_en, 1'b1);
        chk1("dir_fwd", dir_rev, 1'b0);
        u_btn.open_stop;
        chk1("stop_dec", dec, 1'b1);
        chk1("stop_q", qdec, 1'b0);
        wt(30);
        chk1("stop_off", drive_en, 1'b0);
        u_btn.press(1'b1, 1'b0, 12);
        wt(6);
        u_btn.permit(1'b0);
        wt(2);
        chk1("coast", drive_en, 1'b0);
        u_btn.open_stop;
        u_btn.permit(1'b1);
        wr(`RCG_OFF_CTRL, 32'h0000_0007);
        u_btn.press(1'b0, 1'b1, 12);
        wt(6);
        chk1("dir_rev", dir_rev, 1'b1);
        u_btn.permit(1'b0);
        wt(2);
        chk1("quick", qdec, 1'b1);
        wt(30);
        u_btn.permit(1'b1);
        wt(10);
        chk1("hold", drive_en, 1'b0);
        u_btn.press(1'b0, 1'b1, 12);
        wt(6);
        chk1("repress", drive_en, 1'b1);
        wr(`RCG_OFF_CTRL, 32'h0000_000b);
        u_btn.permit(1'b0);
        wt(30);
        chk1("qres_off", drive_en, 1'b0);
        u_btn.permit(1'b1);
        wt(5);
        chk1("resume", drive_en, 1'b1);
        u_btn.press(1'b1, 1'b1, 3);
        wt(2);
        chk1("both", dec, 1'b1);
        wt(30);
        apb(1'b0, `RCG_OFF_STATUS, 32'h0000_0000);
        chk("latches", d & 32'h0000_0060, 32'h0000_0000);
        wr(`RCG_OFF_CTRL, 32'h0000_0002);
        u_btn.terms(8'hfe);
        u_btn.hold(1'b1, 1'b0);
        wt(6);
        chk1("no_permit", drive_en, 1'b0);
        wr(`RCG_OFF_FSEL_HI, 32'h000d_0000);
        wt(4);
        chk1("term6", drive_en, 1'b1);
        u_btn.terms(8'h00);
        wt(2);
        chk1("term6_off", drive_en, 1'b0);
        wr(`RCG_OFF_CTRL, 32'h0000_0000);
        wt(4);
        chk1("always_en", drive_en, 1'b1);
        // reset in mid-run with the forward input still held
        @(posedge pclk);
        presetn <= 1'b0;
        wt(2);
        chk1("rst_mid", drive_en, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        wt(4);
        chk1("rst_blocked", drive_en, 1'b0);
        rd("ctrl_rst", `RCG_OFF_CTRL, 32'h0000_0002);
        u_btn.hold(1'b0, 1'b0);
        wt(2);
        stop_test;
    end
endmodule // rcg_run_gate_test
